// *** include/pmrc_defines.svh ***
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH

// ==========================================================
// Bus widths
`define PMRC_ADDR_W 8
`define PMRC_DATA_W 8

// ==========================================================
// Register byte offsets
`define PMRC_OFF_EN_CLR 8'h34
`define PMRC_OFF_EN_SET 8'h35
`define PMRC_OFF_FLAG 8'h36
`define PMRC_OFF_CAUSE 8'h38

// ==========================================================
// Reset values
`define PMRC_EN_RST 1'b0
`define PMRC_FLAG_RST 8'h00
`define PMRC_CAUSE_RST 8'h01

// ==========================================================
// Field positions
`define PMRC_BIT_RATIO 0
`define PMRC_BIT_POR 0
`define PMRC_BIT_CORE_BOD 1
`define PMRC_BIT_SUPPLY_BOD 2
`define PMRC_BIT_RSV_LO 3
`define PMRC_BIT_EXT 4
`define PMRC_BIT_WDT 5
`define PMRC_BIT_SOFTWARE_SYSTEM_RESET_FLAG 6
`define PMRC_BIT_RSV_HI 7

// ==========================================================
// Divider select width
`define PMRC_DIV_W 3

`endif

// *** include/pmrc_pkg.sv ***
`include "pmrc_defines.svh"

package pmrc_pkg;

    // ==========================================================
    // Register bus request, one cycle per access
    typedef struct packed {
        logic [`PMRC_ADDR_W-1:0] addr;
        logic [`PMRC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pmrc_bus_req_s;

    // ==========================================================
    // Divider ratios of the CPU clock and three bus clocks
    typedef struct packed {
        logic [`PMRC_DIV_W-1:0] cpu_clock_divider_select;
        logic [2:0][`PMRC_DIV_W-1:0] bus_clock_divider_select;
    } pmrc_div_sel_s;

    // ==========================================================
    // Reset sources reported by the reset controller
    typedef struct packed {
        logic software_system_reset_flag;
        logic watchdog_reset_flag;
        logic external_pin_reset_flag;
        logic supply_brownout_flag;
        logic core_brownout_flag;
        logic power_on_flag;
    } pmrc_cause_s;

    // ==========================================================
    // Reset-cause capture sequencer
    typedef enum logic [1:0] {
        PMRC_ST_CAPTURE = 2'b01,
        PMRC_ST_RUN = 2'b10
    } pmrc_state_e;

endpackage

// *** rtl/pmrc_sync2.sv ***
`timescale 1ns/1ps

// ==========================================================
// Two-stage synchroniser; no reset so it tracks during reset
module pmrc_sync2 #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // First stage, read only by the second
    logic [W-1:0] meta_q;

    // Both stages on every rising edge
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end

endmodule

// *** rtl/pmrc_sticky_bit.sv ***
`timescale 1ns/1ps

// ==========================================================
// Sticky flag; a set in the clear cycle wins
module pmrc_sticky_bit (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Event and clear
    input wire logic set,
    input wire logic clr,
    // Flag state
    output logic q
);

    // Set beats clear so no event is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

// *** rtl/pmrc_top.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "pmrc_defines.svh"

// How it works
// - Set alias writes one: enable on
// - Clear alias one: enable off, request dropped
// - Set and clear aliases at separate offsets
// - Flag sets when clock ratios take effect
// - Interrupt high while flag and enable set
// - Flag cleared by writing one; resets zero
// - Flag bits seven to one read zero
// - Cause resets to power-on bit zero
// - Core brown-out reset sets cause bit one
// - Supply brown-out reset sets cause bit two
// - External pin reset sets cause bit four
// - Watchdog reset sets cause bit five
// - Software system reset sets cause bit six
// - Cause bits seven and three read zero
module pmrc_top import pmrc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire pmrc_bus_req_s bus_req,
    output logic [`PMRC_DATA_W-1:0] bus_rdata,
    // Divider logic, same clock
    input wire pmrc_div_sel_s div_programmed,
    input wire pmrc_div_sel_s div_applied,
    // Reset controller, asynchronous levels
    input wire pmrc_cause_s reset_cause_in,
    // Interrupt
    output logic irq
);

    // ==========================================================
    // Declarations

    // Read data register, valid one cycle after the strobe
    logic [`PMRC_DATA_W-1:0] rdata_q;
    // Interrupt output register
    logic irq_q;
    // Shared interrupt enable behind both aliases
    logic en_q;
    // Clock-ready flag
    logic flag_q;
    // Last reset source, reserved bits kept zero
    logic [`PMRC_DATA_W-1:0] cause_q;
    // Capture sequencer
    pmrc_state_e state_q;
    // Ratio match seen in the previous cycle
    logic match_q;
    // Current ratio match and its rising edge
    logic match;
    logic ratio_event;
    // Decoded write strobes
    logic wr_en_set;
    logic wr_en_clr;
    logic wr_flag;
    // Reset sources after synchronisation
    pmrc_cause_s cause_sync;
    // Cause vector in register layout
    logic [`PMRC_DATA_W-1:0] cause_word;

    // ==========================================================
    // Address decode

    // Each alias has its own byte offset
    assign wr_en_set = bus_req.wr && (bus_req.addr == `PMRC_OFF_EN_SET);
    assign wr_en_clr = bus_req.wr && (bus_req.addr == `PMRC_OFF_EN_CLR);
    // Flag register takes a write-one-to-clear
    assign wr_flag = bus_req.wr && (bus_req.addr == `PMRC_OFF_FLAG);

    // ==========================================================
    // Interrupt enable

    // Only bit zero acts; a zero write leaves it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= `PMRC_EN_RST;
        end else if (wr_en_set && bus_req.wdata[`PMRC_BIT_RATIO]) begin
            // Enable without read-modify-write
            en_q <= 1'b1;
        end else if (wr_en_clr && bus_req.wdata[`PMRC_BIT_RATIO]) begin
            // Disable, pending request goes with it
            en_q <= 1'b0;
        end
    end

    // ==========================================================
    // Clock-ratio tracking

    // Ratios in effect equal the programmed ones
    assign match = (div_applied == div_programmed);
    // Only a new settling counts as an event
    assign ratio_event = match && !match_q;

    // Starts high so the boot ratios raise no flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            match_q <= 1'b1;
        end else begin
            match_q <= match;
        end
    end

    // ==========================================================
    // Clock-ready flag

    // Event wins over a clear in the same cycle
    pmrc_sticky_bit u_ratio_flag (
        .clk(clk),
        .rst(rst),
        .set(ratio_event),
        .clr(wr_flag && bus_req.wdata[`PMRC_BIT_RATIO]),
        .q(flag_q)
    );

    // ==========================================================
    // Interrupt output

    // Registered so the pin comes from a flop; one cycle lag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            // Request only while flag and enable are both set
            irq_q <= flag_q && en_q;
        end
    end

    // ==========================================================
    // Reset-cause capture

    // Controller holds its sources through reset and past release
    pmrc_sync2 #(
        .W($bits(pmrc_cause_s))
    ) u_cause_sync (
        .clk(clk),
        .d(reset_cause_in),
        .q(cause_sync)
    );

    // Map sources onto the register layout
    always_comb begin
        cause_word = 8'h00;
        cause_word[`PMRC_BIT_POR] = cause_sync.power_on_flag;
        // Core rail detector
        cause_word[`PMRC_BIT_CORE_BOD] = cause_sync.core_brownout_flag;
        // Supply rail detector
        cause_word[`PMRC_BIT_SUPPLY_BOD] = cause_sync.supply_brownout_flag;
        // External pin
        cause_word[`PMRC_BIT_EXT] = cause_sync.external_pin_reset_flag;
        // Watchdog
        cause_word[`PMRC_BIT_WDT] = cause_sync.watchdog_reset_flag;
        // Software system request
        cause_word[`PMRC_BIT_SOFTWARE_SYSTEM_RESET_FLAG] = cause_sync.software_system_reset_flag;
    end

    // One capture at the first edge after release, then run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= PMRC_ST_CAPTURE;
        end else begin
            unique case (state_q)
                PMRC_ST_CAPTURE: begin
                    state_q <= PMRC_ST_RUN;
                end
                PMRC_ST_RUN: begin
                    state_q <= PMRC_ST_RUN;
                end
                default: begin
                    state_q <= PMRC_ST_CAPTURE;
                end
            endcase
        end
    end

    // Power-on value held until the capture edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cause_q <= `PMRC_CAUSE_RST;
        end else if (state_q == PMRC_ST_CAPTURE) begin
            // Replace earlier causes with this one only
            if (cause_word != 8'h00) begin
                cause_q <= cause_word;
            end else begin
                // No source named: treat as power-on
                cause_q <= `PMRC_CAUSE_RST;
            end
        end
        // Bus writes never reach this register
    end

    // ==========================================================
    // Read path

    // Data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                // Both aliases show the same enable
                `PMRC_OFF_EN_CLR, `PMRC_OFF_EN_SET: begin
                    rdata_q <= {7'h00, en_q};
                end
                // Upper flag bits read zero
                `PMRC_OFF_FLAG: begin
                    rdata_q <= {7'h00, flag_q};
                end
                // Reserved cause bits forced zero
                `PMRC_OFF_CAUSE: begin
                    rdata_q <= cause_q & 8'h77;
                end
                // Unmapped addresses read zero
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // ==========================================================
    // Outputs

    assign bus_rdata = rdata_q;
    assign irq = irq_q;

    // ==========================================================
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Set alias turns the enable on
    en_set_a: assert property (
        wr_en_set && bus_req.wdata[0] |=> en_q
    ) else $error("enable not set by set alias");

    // A zero write to the set alias changes nothing
    en_keep_a: assert property (
        wr_en_set && !bus_req.wdata[0] |=> $stable(en_q)
    ) else $error("enable changed by zero write");

    // Clear alias drops enable, request gone next cycle
    en_clr_a: assert property (
        wr_en_clr && bus_req.wdata[0] |=> !en_q ##1 !irq_q
    ) else $error("clear alias left request pending");

    // Both aliases read back the shared enable
    alias_read_a: assert property (
        bus_req.rd && (bus_req.addr == 8'h34 || bus_req.addr == 8'h35)
        |=> bus_rdata == {7'h00, $past(en_q)}
    ) else $error("alias readback mismatch");

    // Settled ratios raise the flag next edge
    flag_set_a: assert property (
        match && !match_q |=> flag_q
    ) else $error("ratio event missed");

    // Flag with enable yields request, else none
    irq_on_a: assert property (
        flag_q && en_q |=> irq_q
    ) else $error("request missing");
    irq_off_a: assert property (
        !(flag_q && en_q) |=> !irq_q
    ) else $error("request without cause");

    // Write one clears the flag unless an event arrives
    flag_clr_a: assert property (
        wr_flag && bus_req.wdata[0] && !ratio_event |=> !flag_q
    ) else $error("flag not cleared");

    // A set flag only falls on a written one
    flag_hold_a: assert property (
        flag_q && !(wr_flag && bus_req.wdata[0]) |=> flag_q
    ) else $error("flag dropped without clear");

    // Flag and request come out of reset low
    flag_rst_a: assert property (
        $fell(rst) |-> !flag_q && !irq_q
    ) else $error("flag not zero after reset");

    // Reserved flag bits read zero
    flag_rsv_a: assert property (
        bus_req.rd && bus_req.addr == 8'h36 |=> bus_rdata[7:1] == 7'h00
    ) else $error("reserved flag bits nonzero");

    // No named source after reset gives the power-on code
    cause_por_a: assert property (
        state_q == PMRC_ST_CAPTURE && cause_word == 8'h00
        |=> cause_q == 8'h01
    ) else $error("power-on default lost");

    // The captured cause is exactly the reported sources
    cause_map_a: assert property (
        state_q == PMRC_ST_CAPTURE && cause_word != 8'h00
        |=> cause_q == $past(cause_word)
    ) else $error("cause capture wrong");

    // Reserved cause bits stay zero
    cause_rsv_a: assert property (
        !cause_q[7] && !cause_q[3]
    ) else $error("reserved cause bit set");

    // After capture the cause never moves
    cause_hold_a: assert property (
        state_q == PMRC_ST_RUN |=> $stable(cause_q)
    ) else $error("cause changed after capture");

    // Bus writes leave the captured cause alone
    cause_ro_a: assert property (
        bus_req.wr && bus_req.addr == 8'h38 && state_q == PMRC_ST_RUN
        |=> $stable(cause_q)
    ) else $error("cause written by bus");

    // Main scenarios
    irq_seen_c: cover property (
        match && !match_q && en_q ##2 irq_q
    );
    flag_clear_c: cover property (
        flag_q ##1 wr_flag && bus_req.wdata[0] ##1 !flag_q
    );
    wdt_cause_c: cover property (
        state_q == PMRC_ST_RUN && cause_q[5]
    );
    // Event and clear in one cycle, the event wins
    flag_clash_c: cover property (
        ratio_event && wr_flag && bus_req.wdata[0] ##1 flag_q
    );
    // Clear alias withdraws a standing request
    irq_drop_c: cover property (
        irq_q && wr_en_clr && bus_req.wdata[0] ##2 !irq_q
    );

endmodule

// *** sim/test_pmrc_top.sv ***
`timescale 1ns/1ps
`include "pmrc_defines.svh"

// ==========================================================
// Compare macro; case equality so an unknown never matches
`define CHK(nm, ex, got) begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
        bad_count++; \
        $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
end

module test_pmrc_top import pmrc_pkg::*;;
    // Clock and reset
    logic clk;
    logic rst;
    // Register bus
    pmrc_bus_req_s bus_req;
    logic [7:0] bus_rdata;
    // Divider ratios and reset sources
    pmrc_div_sel_s div_programmed;
    pmrc_div_sel_s div_applied;
    pmrc_cause_s reset_cause_in;
    // Interrupt
    logic irq;
    // Bookkeeping
    int bad_count = 0;
    int n_tests = 0;
    int seed = 32'habcc9a03;
    logic [7:0] exp_q[$];
    string name_q[$];
    logic rd_seen = 1'b0;
    // Oldest note, taken off the queues exactly once
    logic [7:0] exp_v;
    string nm_v;

    // ==========================================================
    // Device under test
    pmrc_top pmrc_top_inst (
        .clk(clk),
        .rst(rst),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .div_programmed(div_programmed),
        .div_applied(div_applied),
        .reset_cause_in(reset_cause_in),
        .irq(irq)
    );

    // 100 ns period
    always #50 clk = ~clk;

    // ==========================================================
    // Read monitor: pops the oldest note when read data stands
    always @(posedge clk) begin
        if (rd_seen) begin
            // Pop first: the macro names its arguments twice
            exp_v = exp_q.pop_front();
            nm_v = name_q.pop_front();
            `CHK(nm_v, exp_v, bus_rdata)
        end else if (!rst) begin
            // Outside a read slot the data lines rest at zero
            `CHK("rdata idle", 8'h00, bus_rdata)
        end
        rd_seen <= bus_req.rd & ~rst;
    end

    // ==========================================================
    // Bus tasks; strobes stay up for back-to-back use
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        bus_req.rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        bus_req.addr <= a;
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b1;
        @(posedge clk);
    endtask

    // Drop strobes and let cycles pass
    task automatic idle(input int n);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    // Interrupt sampled mid-cycle, where it is settled
    task automatic chk_irq(input logic e);
        @(negedge clk);
        `CHK("irq", e, irq)
        @(posedge clk);
    endtask

    // Reset with a cause held across the release window
    task automatic do_reset(input pmrc_cause_s c);
        reset_cause_in <= c;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        reset_cause_in <= '0;
    endtask

    // Expected cause byte; no source reported reads as power-on
    function automatic logic [7:0] cause_exp(input logic [5:0] c);
        if (c == 6'h00) begin
            return 8'h01;
        end
        return {1'b0, c[5:3], 1'b0, c[2:0]};
    endfunction

    // Ratio change: mismatch first, then settle on a random value
    task automatic ratio_event();
        logic [11:0] p;
        p = 12'($random(seed));
        div_programmed <= pmrc_div_sel_s'(p);
        div_applied <= pmrc_div_sel_s'(~p);
        idle(2);
        div_applied <= pmrc_div_sel_s'(p);
        idle(3);
    endtask

    // Settle lands in the same cycle as a flag clear
    task automatic ratio_clash();
        logic [11:0] p;
        p = 12'($random(seed));
        div_programmed <= pmrc_div_sel_s'(p);
        div_applied <= pmrc_div_sel_s'(~p);
        idle(2);
        div_applied <= pmrc_div_sel_s'(p);
        wr(`PMRC_OFF_FLAG, 8'h01);
        idle(1);
    endtask

    // ==========================================================
    // Closing task, shared with the watchdog
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard; the full run needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [5:0] c;
        clk = 1'b0;
        rst = 1'b1;
        bus_req = '0;
        div_programmed = '0;
        div_applied = '0;
        reset_cause_in = '0;
        do_reset('0);
        rd(`PMRC_OFF_CAUSE, 8'h01, "cause por");
        rd(`PMRC_OFF_FLAG, 8'h00, "flag reset");
        rd(`PMRC_OFF_EN_SET, 8'h00, "enable reset");
        idle(2);
        $display("test reset values done");

        // Flag rises on ratio match; enable still off
        ratio_event();
        rd(`PMRC_OFF_FLAG, 8'h01, "flag set");
        idle(1);
        chk_irq(1'b0);
        // Zero to set alias is ignored
        wr(`PMRC_OFF_EN_SET, 8'h00);
        rd(`PMRC_OFF_EN_CLR, 8'h00, "set zero");
        wr(`PMRC_OFF_EN_SET, 8'hff);
        rd(`PMRC_OFF_EN_CLR, 8'h01, "set alias");
        idle(2);
        chk_irq(1'b1);
        // Zero to clear alias is ignored, one withdraws request
        wr(`PMRC_OFF_EN_CLR, 8'hfe);
        rd(`PMRC_OFF_EN_SET, 8'h01, "clear zero");
        wr(`PMRC_OFF_EN_CLR, 8'h01);
        rd(`PMRC_OFF_EN_SET, 8'h00, "clear alias");
        idle(2);
        chk_irq(1'b0);
        $display("test enable aliases done");

        // Flag clearing: zero bit ignored, one clears
        wr(`PMRC_OFF_EN_SET, 8'h01);
        wr(`PMRC_OFF_FLAG, 8'h00);
        rd(`PMRC_OFF_FLAG, 8'h01, "flag w0");
        wr(`PMRC_OFF_FLAG, 8'h01);
        rd(`PMRC_OFF_FLAG, 8'h00, "flag w1c");
        idle(2);
        chk_irq(1'b0);
        // Repeated events with random ratios, enable on
        repeat (3) begin
            ratio_event();
            chk_irq(1'b1);
            wr(`PMRC_OFF_FLAG, 8'h01);
            idle(2);
            chk_irq(1'b0);
        end
        // Settle and clear in one cycle: the set wins
        ratio_clash();
        rd(`PMRC_OFF_FLAG, 8'h01, "set wins");
        idle(1);
        chk_irq(1'b1);
        wr(`PMRC_OFF_FLAG, 8'h01);
        idle(2);
        chk_irq(1'b0);
        $display("test clock ready done");

        // Cause is read-only; unmapped read returns zero
        // Reserved cause bits are written as zero
        wr(`PMRC_OFF_CAUSE, 8'($random(seed)) & 8'h77);
        rd(`PMRC_OFF_CAUSE, 8'h01, "cause ro");
        rd(8'h37, 8'h00, "unmapped");
        idle(2);
        $display("test read-only done");

        // Each reset source alone, then random mixes
        for (int i = 0; i < 9; i++) begin
            c = (i < 6) ? 6'(1 << i) : 6'($random(seed));
            do_reset(pmrc_cause_s'(c));
            rd(`PMRC_OFF_CAUSE, cause_exp(c), "cause");
            idle(2);
        end
        // Reset clears enable and flag again
        rd(`PMRC_OFF_EN_CLR, 8'h00, "enable again");
        rd(`PMRC_OFF_FLAG, 8'h00, "flag again");
        idle(2);
        $display("test reset causes done");
        test_done();
    end
endmodule
